// [inc/port_chg_pkg.sv]
package port_chg_pkg;
  // Change word bit positions
  localparam int unsigned CONN_BIT = 0;
  localparam int unsigned OVC_BIT = 3;
  localparam int unsigned RST_BIT = 4;
  localparam int unsigned WRST_BIT = 5;
  localparam int unsigned LINK_BIT = 6;
  localparam int unsigned CFGERR_BIT = 7;
  localparam logic [15:0] CHANGE_RESET = 16'h0000;
  localparam logic [31:0] EXT_RESET = 32'h00000000;
  // Extended status field positions
  localparam int unsigned RX_SPEED_LSB = 0;
  localparam int unsigned TX_SPEED_LSB = 4;
  localparam int unsigned RX_LANE_LSB = 8;
  localparam int unsigned TX_LANE_LSB = 12;

  // Flag index for clear requests
  typedef enum logic [5:0] {
    SEL_CONN = 6'b000001,
    SEL_OVC = 6'b000010,
    SEL_RST = 6'b000100,
    SEL_WRST = 6'b001000,
    SEL_LINK = 6'b010000,
    SEL_CFGERR = 6'b100000
  } flag_sel_e;

  // Downstream port states seen by this block
  typedef enum logic [3:0] {
    PS_OFF = 4'b0001,
    PS_RESETTING = 4'b0010,
    PS_ENABLED = 4'b0100,
    PS_ERROR = 4'b1000
  } port_state_e;

  typedef struct packed {
    logic connected;
    logic over_current;
    logic power_on;
    logic enabled;
    logic reset_done;
    logic reset_warm;
    logic u3_to_u0_host;
    logic u3_to_u0_wake;
    logic loopback_entered;
    logic compliance_entered;
    logic inactive_with_rx_term;
    logic config_fail;
    logic other_port_ovc_off;
  } port_events_s;

  typedef struct packed {
    logic [3:0] rx_speed_id;
    logic [3:0] tx_speed_id;
    logic [3:0] rx_lanes;
    logic [3:0] tx_lanes;
  } link_params_s;

  typedef struct packed {
    logic [15:0] change_r;
    logic [31:0] rdata_r;
    logic rvalid_r;
    logic conn_prev_r;
    logic ovc_prev_r;
    port_state_e state_r;
  } chg_state_s;
endpackage

// [rtl/hub_port_change_and_ext_status.sv]
// Behaviour
// RULE_01 - Change word bit 6 marks a link status change.
// RULE_02 - Change word bit 7 marks failure to configure the link partner.
// RULE_03 - Connection change sets on connect edge; cleared by request or power off. The code also sets it on a disconnect edge.
// RULE_04 - Over-current change sets on either edge or other-port powered-off reset.
// RULE_05 - Reset change sets on resetting-to-enabled after any reset.
// RULE_06 - Warm reset change sets only when that transition follows warm reset.
// RULE_07 - Link change sets on host U3-U0, loopback, compliance, inactive with terminations.
// RULE_08 - Remote wake U3-U0 never sets link change; clears by request or power off.
// RULE_09 - Config error sets on link configuration failure; clears by request or power.
// RULE_10 - Configuration failure moves the port state into error.
// RULE_11 - Extended word is returned only for the extended status type.
// RULE_12 - Rx speed ID bits 0-3, Tx speed ID bits 4-7.
// RULE_13 - Rx lane count bits 8-11, Tx lane count bits 12-15.
// RULE_14 - Speed and lane fields valid only while port enabled.
// RULE_15 - Host decodes speed ID through capability descriptor attributes.
// RULE_16 - Host computes port speed as sublink speed times lanes.
// RULE_17 - Flags clear by request or hub reset; set requests ignored.
// RULE_18 - Reserved bits read as zero.
`timescale 1ns/1ps
module hub_port_change_and_ext_status (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Port events
  input port_chg_pkg::port_events_s events,
  input port_chg_pkg::link_params_s link_params,
  // Status requests
  input wire logic status_req,
  input wire logic status_ext,
  input wire logic clear_req,
  input port_chg_pkg::flag_sel_e clear_sel,
  input wire logic set_req,
  // Answers
  output logic status_valid,
  output logic [31:0] status_data,
  output logic [15:0] port_change,
  output port_chg_pkg::port_state_e port_state
);
  port_chg_pkg::chg_state_s st_r;
  port_chg_pkg::chg_state_s st_nxt;
  logic [15:0] set_v;
  logic [15:0] clr_v;
  logic [15:0] ext_v;

  function automatic logic [15:0] sel_mask(input port_chg_pkg::flag_sel_e s);
    logic [15:0] m;
    m = 16'h0000;
    case (s)
      port_chg_pkg::SEL_CONN: m[port_chg_pkg::CONN_BIT] = 1'b1;
      port_chg_pkg::SEL_OVC: m[port_chg_pkg::OVC_BIT] = 1'b1;
      port_chg_pkg::SEL_RST: m[port_chg_pkg::RST_BIT] = 1'b1;
      port_chg_pkg::SEL_WRST: m[port_chg_pkg::WRST_BIT] = 1'b1;
      port_chg_pkg::SEL_LINK: m[port_chg_pkg::LINK_BIT] = 1'b1;
      port_chg_pkg::SEL_CFGERR: m[port_chg_pkg::CFGERR_BIT] = 1'b1;
      default: m = 16'h0000;
    endcase
    return m;
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    set_v = 16'h0000;
    clr_v = 16'h0000;
    ext_v = 16'h0000;
    // RULE_03 connect or disconnect edge
    set_v[port_chg_pkg::CONN_BIT] = events.connected ^ st_r.conn_prev_r;
    // RULE_04 over-current edges
    set_v[port_chg_pkg::OVC_BIT] = (events.over_current ^ st_r.ovc_prev_r) | events.other_port_ovc_off;
    // RULE_05 reset complete
    set_v[port_chg_pkg::RST_BIT] = events.reset_done && st_r.state_r == port_chg_pkg::PS_RESETTING;
    // RULE_06 warm reset only
    set_v[port_chg_pkg::WRST_BIT] = set_v[port_chg_pkg::RST_BIT] && events.reset_warm;
    // RULE_01 RULE_07 RULE_08 link events, wake excluded
    set_v[port_chg_pkg::LINK_BIT] = events.u3_to_u0_host | events.loopback_entered |
                                    events.compliance_entered | events.inactive_with_rx_term;
    // RULE_02 RULE_09 config failure
    set_v[port_chg_pkg::CFGERR_BIT] = events.config_fail;
    // RULE_17 clear by request; set requests ignored
    if (clear_req && !set_req)
      clr_v = sel_mask(clear_sel);
    // RULE_03 RULE_05 RULE_09 power-off hold, over-current exempt
    if (!events.power_on)
    begin
      clr_v = clr_v | 16'h00f1;
      set_v = set_v & 16'h0008;
    end
    // Set wins over request clear; RULE_18 reserved zero
    st_nxt.change_r = ((st_r.change_r & ~clr_v) | set_v) & 16'h00f9;
    st_nxt.conn_prev_r = events.connected;
    st_nxt.ovc_prev_r = events.over_current;
    // RULE_10 port state tracking
    case (st_r.state_r)
      port_chg_pkg::PS_OFF: if (events.power_on) st_nxt.state_r = port_chg_pkg::PS_RESETTING;
      port_chg_pkg::PS_RESETTING: if (events.reset_done) st_nxt.state_r = port_chg_pkg::PS_ENABLED;
      port_chg_pkg::PS_ENABLED: if (!events.enabled) st_nxt.state_r = port_chg_pkg::PS_RESETTING;
      port_chg_pkg::PS_ERROR: st_nxt.state_r = port_chg_pkg::PS_ERROR;
      default: st_nxt.state_r = port_chg_pkg::PS_OFF;
    endcase
    if (events.config_fail)
      st_nxt.state_r = port_chg_pkg::PS_ERROR;
    if (!events.power_on)
      st_nxt.state_r = port_chg_pkg::PS_OFF;
    // RULE_12 RULE_13 RULE_14 extended fields gated by enable
    if (events.enabled)
    begin
      ext_v[port_chg_pkg::RX_SPEED_LSB +: 4] = link_params.rx_speed_id;
      ext_v[port_chg_pkg::TX_SPEED_LSB +: 4] = link_params.tx_speed_id;
      ext_v[port_chg_pkg::RX_LANE_LSB +: 4] = link_params.rx_lanes;
      ext_v[port_chg_pkg::TX_LANE_LSB +: 4] = link_params.tx_lanes;
    end
    st_nxt.rvalid_r = status_req;
    // RULE_11 extended word only on extended type
    if (status_req)
      st_nxt.rdata_r = status_ext ? {16'h0000, ext_v} : {16'h0000, st_r.change_r};
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_r.change_r <= port_chg_pkg::CHANGE_RESET;
      st_r.rdata_r <= port_chg_pkg::EXT_RESET;
      st_r.rvalid_r <= 1'b0;
      st_r.conn_prev_r <= 1'b0;
      st_r.ovc_prev_r <= 1'b0;
      st_r.state_r <= port_chg_pkg::PS_OFF;
    end
    else
      st_r <= st_nxt;
  end

  assign status_valid = st_r.rvalid_r;
  assign status_data = st_r.rdata_r;
  assign port_change = st_r.change_r;
  assign port_state = st_r.state_r;

  AST_CONN_SET: assert property (@(posedge core_clk) disable iff (reset) // RULE_03
    (events.connected != $past(events.connected)) && events.power_on && !$past(reset) |=> port_change[0])
    else $error("connect change not latched");
  AST_OVC_SET: assert property (@(posedge core_clk) disable iff (reset) // RULE_04
    events.other_port_ovc_off |=> port_change[3])
    else $error("over-current change not latched");
  AST_WRST: assert property (@(posedge core_clk) disable iff (reset) // RULE_06
    $rose(port_change[5]) |-> $past(events.reset_warm) && $past(events.reset_done))
    else $error("warm reset change without warm reset");
  AST_WAKE: assert property (@(posedge core_clk) disable iff (reset) // RULE_08
    $rose(port_change[6]) |-> !$past(events.u3_to_u0_wake) || $past(events.u3_to_u0_host) ||
    $past(events.loopback_entered) || $past(events.compliance_entered) || $past(events.inactive_with_rx_term))
    else $error("link change from remote wake");
  AST_LINK: assert property (@(posedge core_clk) disable iff (reset) // RULE_07
    events.compliance_entered && events.power_on |=> port_change[6])
    else $error("link change missed");
  AST_CFG_ERR: assert property (@(posedge core_clk) disable iff (reset) // RULE_10
    events.config_fail && events.power_on |=> port_state == port_chg_pkg::PS_ERROR && port_change[7])
    else $error("config failure not handled");
  AST_POWER_OFF: assert property (@(posedge core_clk) disable iff (reset) // RULE_05
    !events.power_on |=> (port_change & 16'h00f1) == 16'h0000)
    else $error("flags held while power off");
  AST_EXT: assert property (@(posedge core_clk) disable iff (reset) // RULE_14
    status_req && status_ext && !events.enabled |=> status_valid && status_data == 32'h00000000)
    else $error("extended fields leaked while disabled");
  AST_RSVD: assert property (@(posedge core_clk) disable iff (reset) // RULE_18
    (port_change & 16'hff06) == 16'h0000 ##0 status_data[31:16] == 16'h0000)
    else $error("reserved bits nonzero");
  AST_CHG_READ: assert property (@(posedge core_clk) disable iff (reset) // RULE_11
    status_req && !status_ext |=> status_data[15:0] == $past(port_change))
    else $error("change word read wrong");
  COV_CONN: cover property (@(posedge core_clk) $rose(port_change[0]));
  COV_RESET: cover property (@(posedge core_clk) $rose(port_change[5]));
  COV_ERR: cover property (@(posedge core_clk) port_state == port_chg_pkg::PS_ERROR);
  COV_EXT: cover property (@(posedge core_clk) status_valid && status_data != 32'h00000000);
endmodule

// [verif/host_model.sv]
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic core_clk,
  // Requests
  output logic status_req,
  output logic status_ext,
  output logic clear_req,
  output port_chg_pkg::flag_sel_e clear_sel,
  output logic set_req,
  // Answers
  input wire logic status_valid,
  input wire logic [31:0] status_data
);
  initial
  begin
    status_req = 1'b0;
    status_ext = 1'b0;
    clear_req = 1'b0;
    clear_sel = port_chg_pkg::SEL_CONN;
    set_req = 1'b0;
  end
  function automatic int port_rate(input logic [3:0] lanes, input int lane_rate);
    return lane_rate * (int'(lanes) + 1);
  endfunction
  task automatic get_status(input logic ext, output logic [31:0] word, output logic ok);
    @(negedge core_clk);
    status_req = 1'b1;
    status_ext = ext;
    @(negedge core_clk);
    status_req = 1'b0;
    ok = status_valid;
    word = status_data;
  endtask
  task automatic clear_flag(input port_chg_pkg::flag_sel_e sel, input logic s);
    @(negedge core_clk);
    clear_req = 1'b1;
    clear_sel = sel;
    set_req = s;
    @(negedge core_clk);
    clear_req = 1'b0;
    set_req = 1'b0;
  endtask
endmodule

// [verif/hub_port_change_and_ext_status_bench.sv]
`timescale 1ns/1ps
module hub_port_change_and_ext_status_bench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  port_chg_pkg::port_events_s ev = '0;
  port_chg_pkg::link_params_s lp = '{4'h3, 4'h5, 4'h1, 4'h2};
  logic sreq, sext, creq, sreq_set, sval;
  port_chg_pkg::flag_sel_e csel;
  logic [31:0] sdata;
  logic [15:0] chg;
  port_chg_pkg::port_state_e pst;
  int fail_count = 0;
  int comparisons = 0;
  // Host U3-U0, loopback, compliance and inactive-with-terminations event bits
  logic [12:0] link_ev [4] = '{13'h0040, 13'h0010, 13'h0008, 13'h0004};
  hub_port_change_and_ext_status dut (.core_clk(core_clk), .reset(reset), .events(ev), .link_params(lp),
    .status_req(sreq), .status_ext(sext), .clear_req(creq), .clear_sel(csel), .set_req(sreq_set),
    .status_valid(sval), .status_data(sdata), .port_change(chg), .port_state(pst));
  host_model host (.core_clk(core_clk), .status_req(sreq), .status_ext(sext), .clear_req(creq),
    .clear_sel(csel), .set_req(sreq_set), .status_valid(sval), .status_data(sdata));
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic read_chk(input logic ext, input logic [31:0] exp);
    logic [31:0] w;
    logic ok;
    host.get_status(ext, w, ok);
    compare({31'h0, ok}, 32'h00000001);
    compare(w, exp);
    // Change word output must agree once the request has been answered
    if (!ext)
      compare({16'h0000, chg}, exp);
  endtask
  task automatic pulse(input logic [12:0] m);
    @(negedge core_clk);
    ev = ev | m;
    @(negedge core_clk);
    ev = ev & ~m;
  endtask
  task automatic state_chk(input port_chg_pkg::port_state_e s);
    compare({28'h0, pst}, {28'h0, s});
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #80000;
    fail_count++;
    finish_test();
  end
  task automatic test_reset();
    read_chk(1'b0, 32'h0);
    state_chk(port_chg_pkg::PS_OFF);
    $display("test reset done");
  endtask
  task automatic test_connect();
    ev[10] = 1'b1;
    ev[12] = 1'b1;
    read_chk(1'b0, 32'h1);
    host.clear_flag(port_chg_pkg::SEL_CONN, 1'b1);
    read_chk(1'b0, 32'h1);
    host.clear_flag(port_chg_pkg::SEL_CONN, 1'b0);
    read_chk(1'b0, 32'h0);
    $display("test connect done");
  endtask
  task automatic test_reset_change();
    ev[9] = 1'b1;
    pulse(13'h180);
    read_chk(1'b0, 32'h30);
    state_chk(port_chg_pkg::PS_ENABLED);
    host.clear_flag(port_chg_pkg::SEL_RST, 1'b0);
    host.clear_flag(port_chg_pkg::SEL_WRST, 1'b0);
    ev[9] = 1'b0;
    @(negedge core_clk);
    ev[9] = 1'b1;
    pulse(13'h100);
    read_chk(1'b0, 32'h10);
    host.clear_flag(port_chg_pkg::SEL_RST, 1'b0);
    $display("test reset change done");
  endtask
  task automatic test_link();
    pulse(13'h020);
    read_chk(1'b0, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      pulse(link_ev[i]);
      read_chk(1'b0, 32'h40);
      host.clear_flag(port_chg_pkg::SEL_LINK, 1'b0);
      read_chk(1'b0, 32'h0);
    end
    $display("test link change done");
  endtask
  task automatic test_over_current();
    ev[11] = 1'b1;
    pulse(13'h020);
    ev[10] = 1'b0;
    read_chk(1'b0, 32'h8);
    host.clear_flag(port_chg_pkg::SEL_OVC, 1'b0);
    pulse(13'h001);
    read_chk(1'b0, 32'h8);
    host.clear_flag(port_chg_pkg::SEL_OVC, 1'b0);
    ev[11] = 1'b0;
    read_chk(1'b0, 32'h8);
    host.clear_flag(port_chg_pkg::SEL_OVC, 1'b0);
    $display("test over current done");
  endtask
  task automatic test_config_error();
    ev[10] = 1'b1;
    pulse(13'h002);
    read_chk(1'b0, 32'h80);
    state_chk(port_chg_pkg::PS_ERROR);
    ev[10] = 1'b0;
    read_chk(1'b0, 32'h0);
    $display("test config error done");
  endtask
  task automatic test_extended();
    read_chk(1'b1, 32'h00002153);
    read_chk(1'b1, 32'h00002153);
    ev[9] = 1'b0;
    read_chk(1'b1, 32'h0);
    // Disconnect while powered also latches a connection change
    ev[12] = 1'b0;
    ev[10] = 1'b1;
    pulse(13'h002);
    read_chk(1'b0, 32'h81);
    read_chk(1'b1, 32'h0);
    $display("test extended word done");
  endtask
  initial
  begin
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    test_reset();
    test_connect();
    test_reset_change();
    test_link();
    test_over_current();
    test_config_error();
    test_extended();
    finish_test();
  end
endmodule
